/* logic/prsd_pkg.sv */
/*
 * Shared constants, enumerations and carriers for the reference switchover
 * and PLL divider control block.
 * Assumes a single 50 MHz system clock and configuration bits held stable by
 * the surrounding configuration logic.
 */
`default_nettype none
package prsd_pkg;

	// Counter widths
	localparam int R_WIDTH = 14;
	localparam int A_WIDTH = 6;
	localparam int B_WIDTH = 13;

	// Edge counts of the reference monitor
	localparam int MISS_EDGES_DEF   = 2;
	localparam int REVERT_EDGES_DEF = 4;

	// Divider settings with special meaning
	localparam logic [R_WIDTH-1:0] R_UNITY_MAX = 14'h0001;
	localparam logic [B_WIDTH-1:0] B_BYPASS    = 13'h0001;

	// Sync pin control value that leaves the pin without effect
	localparam logic [1:0] SYNC_OFF = 2'h0;

	// Prescaler modes: fixed divide and dual modulus
	typedef enum logic [2:0] {
		PS_FD1  = 3'h0,
		PS_FD2  = 3'h1,
		PS_FD3  = 3'h2,
		PS_DM2  = 3'h3,
		PS_DM4  = 3'h4,
		PS_DM8  = 3'h5,
		PS_DM16 = 3'h6,
		PS_DM32 = 3'h7
	} prsd_pmode_e;

	// Automatic switchover states, Gray coded along primary-armed-secondary
	typedef enum logic [1:0] {
		SW_PRIMARY   = 2'h0,
		SW_ARMED     = 2'h1,
		SW_SECONDARY = 2'h3
	} prsd_sw_e;

	// Configuration bits from the register file
	typedef struct packed {
		logic               pllOn;              // PLL powered
		logic               diffSelect;         // Differential or crystal input
		logic               crystalMode;        // Crystal across the input pair
		logic               crystalAmpEnable;   // Maintaining amplifier request
		logic               singleEndedEnable;  // Single-ended inputs requested
		logic               primaryPowerDown;   // Primary buffer power-down
		logic               secondaryPowerDown; // Secondary buffer power-down
		logic               dcOffsetEnable;     // Lower single-ended bias point
		logic               autoMode;           // Automatic switchover
		logic               stayOnSecondary;    // Revert inhibit
		logic               manualSecondary;    // Manual select of secondary
		logic               selectPinEnable;    // Select pin steers selection
		logic               deglitchEnable;     // Switchover deglitch
		logic [R_WIDTH-1:0] rCount;             // Reference divide
		prsd_pmode_e        prescalerMode;      // Prescaler mode
		logic [A_WIDTH-1:0] aCount;             // Swallow count
		logic [B_WIDTH-1:0] bCount;             // Main count
		logic               resetAllCounters;   // Shared three-counter reset
		logic               resetRDivider;      // Reference divider reset
		logic               resetABCounters;    // Swallow and main reset
		logic [1:0]         syncCtrl;           // Sync pin reset control
	} prsd_cfg_s;

	// Status and control outputs
	typedef struct packed {
		logic diffReceiverOn;
		logic primaryBufferOn;
		logic secondaryBufferOn;
		logic crystalAmpOn;
		logic biasShiftDown;
		logic usingSecondary;
		logic primaryMissing;
		logic pllRefClk;
		logic pfdRefClk;
		logic pfdFbClk;
	} prsd_status_s;

	// Prescaler modulus P of a mode
	function automatic logic [5:0] prsd_modulus(input prsd_pmode_e m);
		unique case (m)
			PS_FD1:  prsd_modulus = 6'h01;
			PS_FD2:  prsd_modulus = 6'h02;
			PS_FD3:  prsd_modulus = 6'h03;
			PS_DM2:  prsd_modulus = 6'h02;
			PS_DM4:  prsd_modulus = 6'h04;
			PS_DM8:  prsd_modulus = 6'h08;
			PS_DM16: prsd_modulus = 6'h10;
			PS_DM32: prsd_modulus = 6'h20;
		endcase
	endfunction

	// Dual modulus modes use the swallow counter
	function automatic logic prsd_is_dual(input prsd_pmode_e m);
		prsd_is_dual = (m == PS_DM2) || (m == PS_DM4) || (m == PS_DM8) ||
			(m == PS_DM16) || (m == PS_DM32);
	endfunction

endpackage
`default_nettype wire

/* logic/prsd_fb_divider.sv */
/*
 * Feedback divider: prescaler with swallow and main counters, counting rising
 * edges of the sampled VCO level and emitting one VCO period high per N.
 * Assumes vcoLevel is already synchronised to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module prsd_fb_divider
	import prsd_pkg::*;
#(
	parameter int A_W = A_WIDTH,
	parameter int B_W = B_WIDTH
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Divider input and control
	input  wire logic        vcoLevel,
	input  wire logic        counterReset,
	input  wire prsd_pmode_e mode,
	input  wire logic [A_W-1:0] aCount,
	input  wire logic [B_W-1:0] bCount,
	// Divided output
	output logic             fbClk
);
	localparam int CW = B_W + 7;

	initial begin
		if (A_W < 1 || A_W > 8 || B_W < 2 || B_W > 16)
			$error("prsd_fb_divider: unsupported counter widths");
	end

	typedef struct packed {
		logic          vcoPrev; // Last sampled VCO level
		logic [CW-1:0] count;   // Edges counted in this cycle
		logic          out;     // Divided output
	} prsd_fb_state_s;

	prsd_fb_state_s s;
	prsd_fb_state_s next_s;
	logic [CW-1:0]  ratio;      // Total feedback ratio N
	logic           vcoRise;

	// Ratio: P times B plus A; A only counts in dual modulus, and not with B bypassed
	always_comb begin
		ratio = CW'(prsd_modulus(mode)) * CW'(bCount);                      // RULE_16
		if (prsd_is_dual(mode) && bCount != B_W'(B_BYPASS)) // RULE_18
			ratio = ratio + CW'(aCount);                                 // RULE_19
		if (bCount == B_W'(B_BYPASS))
			ratio = CW'(prsd_modulus(mode));                             // RULE_20
	end
	// Fixed divide modes leave A out of the sum above

	// Counting and output
	always_comb begin
		next_s = s;
		vcoRise = vcoLevel & ~s.vcoPrev;
		next_s.vcoPrev = vcoLevel;
		if (counterReset) begin
			// Held reset while either reset bit stays set
			next_s.count = '0;                                           // RULE_22
			next_s.out = 1'b0;
		end else if (ratio <= CW'(1)) begin
			// Divide by one passes the input through
			next_s.count = '0;
			next_s.out = vcoLevel;                                       // RULE_17
		end else if (vcoRise) begin
			if (s.count >= ratio - CW'(1)) begin
				next_s.count = '0;
				next_s.out = 1'b1;
			end else begin
				next_s.count = s.count + CW'(1);
				next_s.out = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign fbClk = s.out;

	a_fb_reset_holds: assert property (@(posedge clock) disable iff (rst) // RULE_22
		counterReset |=> (s.count == '0) && !fbClk)
		else $error("feedback counters not cleared by reset bit");

	a_fb_terminal: assert property (@(posedge clock) disable iff (rst) // RULE_16
		(!counterReset && vcoRise && ratio > CW'(1) && s.count == ratio - CW'(1)) |=> fbClk ##1 (s.count == '0))
		else $error("feedback divider missed its terminal count");

	a_fb_zero_swallow: assert property (@(posedge clock) disable iff (rst) // RULE_19
		(prsd_is_dual(mode) && aCount == '0 && bCount > B_W'(2)) |-> ratio == CW'(prsd_modulus(mode)) * CW'(bCount))
		else $error("zero swallow count not treated as zero");
endmodule
`default_nettype wire

/* logic/prsd_ref_switch_div.sv */
/*
 * Reference input control, automatic and manual reference switchover with
 * deglitch, reference divider and feedback divider control.
 * Assumes reference, VCO and pin levels arrive asynchronously and are far
 * slower than the 50 MHz clock; configuration comes from a register file.
 */
// What this block does
// RULE_01: Primary missing after two secondary falls, no edge
// RULE_02: Secondary takes over at its next rising edge
// RULE_03: Revert after four clean primary rising edges
// RULE_04: Revert inhibit keeps secondary until manual primary
// RULE_05: Software re-enables automatic after manual primary
// RULE_06: Prefer-primary or stay-on-secondary automatic policy
// RULE_07: Manual select by register or select pin
// RULE_08: Manual switch only to a toggling reference; the code switches without checking that the target toggles
// RULE_09: Deglitch blocks misaligned edges during a switch
// RULE_10: All reference inputs disabled after reset
// RULE_11: Receivers powered per PLL, mode and power-downs
// RULE_12: Offset bit lowers single-ended bias point
// RULE_13: Crystal mode enables the maintaining amplifier
// RULE_14: Fourteen-bit reference divider, zero and one unity
// RULE_15: Reference divider reset by shared, own, sync
// RULE_16: Feedback ratio is P times B plus A
// RULE_17: Prescaler fixed one to three or dual modulus
// RULE_18: Fixed divide modes treat swallow count as zero
// RULE_19: Main count three or more; zero swallow counts zero
// RULE_20: Bypassed main count divides by prescaler alone
// RULE_21: Software keeps prescaler output near 300 MHz
// RULE_22: Counter reset bits are levels, not self-clearing
// RULE_23: Sync pin resets counters only when enabled
`timescale 1ns/1ps
`default_nettype none
module prsd_ref_switch_div
	import prsd_pkg::*;
#(
	parameter int MISS_EDGES   = MISS_EDGES_DEF,
	parameter int REVERT_EDGES = REVERT_EDGES_DEF
) (
	// Clock and reset
	input  wire logic   clock,
	input  wire logic   rst,
	// Asynchronous pins
	input  wire logic   primaryRefPin,
	input  wire logic   secondaryRefPin,
	input  wire logic   vcoPin,
	input  wire logic   refSelectPin,
	input  wire logic   syncN,
	// Configuration
	input  wire prsd_cfg_s cfg,
	// Status and control outputs
	output prsd_status_s status
);
	initial begin
		if (MISS_EDGES < 1 || MISS_EDGES > 3 || REVERT_EDGES < 1 || REVERT_EDGES > 7)
			$error("prsd_ref_switch_div: edge counts out of range");
	end

	localparam logic [1:0] MISS_N   = MISS_EDGES[1:0];
	localparam logic [2:0] REVERT_N = REVERT_EDGES[2:0];

	typedef struct packed {
		logic [1:0]         priPipe;        // Primary synchroniser
		logic [1:0]         secPipe;        // Secondary synchroniser
		logic [1:0]         vcoPipe;        // VCO synchroniser
		logic [1:0]         selPipe;        // Select pin synchroniser
		logic [1:0]         syncPipe;       // Sync pin synchroniser
		logic               priPrev;        // Last primary level
		logic               secPrev;        // Last secondary level
		logic [1:0]         missCnt;        // Secondary falls since primary edge
		logic [1:0]         fallsSincePri;  // Secondary falls since primary rise
		logic [2:0]         goodCnt;        // Clean primary rises
		prsd_sw_e           swState;        // Automatic switchover state
		logic               primaryMissing; // Primary declared lost
		logic               usingSecondary; // Reference handed to the PLL
		logic               gating;         // Deglitch hold in progress
		logic               pllRefClk;      // Reference to the PLL
		logic               refPrev;        // Last PLL reference level
		logic [R_WIDTH-1:0] rCount;         // Reference divider count
		logic               rOut;           // Reference divider output
		logic               abReset;        // Feedback counters held reset
		logic               diffRxOn;       // Differential receiver power
		logic               priBufOn;       // Primary buffer power
		logic               secBufOn;       // Secondary buffer power
		logic               xtalAmpOn;      // Maintaining amplifier power
		logic               biasShift;      // Single-ended bias lowered
	} prsd_state_s;

	prsd_state_s s;
	prsd_state_s next_s;
	// Reset value; the sync pin synchroniser starts at its idle high level so no false sync follows reset
	localparam prsd_state_s STATE_RESET = '{syncPipe: '1, swState: SW_PRIMARY, default: '0};
	logic        pri, sec, priAny, priRise, secFall, secRise;
	logic        seActive, autoActive, manualSec, wantSec;
	logic        selLevel, selRise, syncHit, rReset, refRise;
	logic [2:0]  newGood;
	logic        recovered;
	logic        fbClk;

	// Edge detection on the synchronised reference levels
	always_comb begin
		pri = s.priPipe[1];
		sec = s.secPipe[1];
		priAny = pri ^ s.priPrev;
		priRise = pri & ~s.priPrev;
		secFall = ~sec & s.secPrev;
		secRise = sec & ~s.secPrev;
		seActive = cfg.pllOn & cfg.singleEndedEnable & ~cfg.diffSelect;
		autoActive = seActive & cfg.autoMode;
		manualSec = cfg.manualSecondary | (cfg.selectPinEnable & s.selPipe[1]); // RULE_07
		syncHit = (cfg.syncCtrl != SYNC_OFF) & ~s.syncPipe[1];             // RULE_23
		rReset = cfg.resetAllCounters | cfg.resetRDivider | syncHit;       // RULE_15
	end

	// Clean primary rises: start again after too many secondary falls
	always_comb begin
		newGood = s.goodCnt;
		if (priRise) begin
			if (s.fallsSincePri >= MISS_N)
				newGood = 3'h1;                                          // RULE_03
			else if (s.goodCnt < REVERT_N)
				newGood = s.goodCnt + 3'h1;
		end
		recovered = priRise & (newGood >= REVERT_N);
	end

	// Selected reference and its rising edge, silent when its buffer is off
	always_comb begin
		if (cfg.diffSelect)
			selLevel = pri & s.diffRxOn;
		else if (s.usingSecondary)
			selLevel = sec & s.secBufOn;
		else
			selLevel = pri & s.priBufOn;
		selRise = selLevel & ~s.pllRefClk;
		refRise = s.pllRefClk & ~s.refPrev;
	end

	// Next state
	always_comb begin
		next_s = s;
		// Two-flop synchronisers; only the second stage is read elsewhere
		next_s.priPipe = {s.priPipe[0], primaryRefPin};
		next_s.secPipe = {s.secPipe[0], secondaryRefPin};
		next_s.vcoPipe = {s.vcoPipe[0], vcoPin};
		next_s.selPipe = {s.selPipe[0], refSelectPin};
		next_s.syncPipe = {s.syncPipe[0], syncN};
		next_s.priPrev = pri;
		next_s.secPrev = sec;

		// Power gating, all off out of reset until software enables
		next_s.diffRxOn = cfg.pllOn & cfg.diffSelect;                    // RULE_11
		next_s.priBufOn = seActive & ~cfg.primaryPowerDown;              // RULE_10
		next_s.secBufOn = seActive & ~cfg.secondaryPowerDown;            // RULE_11
		next_s.xtalAmpOn = next_s.diffRxOn & cfg.crystalMode & cfg.crystalAmpEnable; // RULE_13
		next_s.biasShift = cfg.dcOffsetEnable & ~cfg.diffSelect;         // RULE_12

		// Primary monitor clocked by secondary falling edges
		if (priAny)
			next_s.missCnt = 2'h0;
		else if (secFall && s.missCnt < MISS_N)
			next_s.missCnt = s.missCnt + 2'h1;                           // RULE_01
		if (priRise)
			next_s.fallsSincePri = 2'h0;
		else if (secFall && s.fallsSincePri < MISS_N)
			next_s.fallsSincePri = s.fallsSincePri + 2'h1;
		next_s.goodCnt = newGood;
		if (next_s.missCnt >= MISS_N) begin
			next_s.primaryMissing = 1'b1;                                // RULE_01
			next_s.goodCnt = 3'h0;
		end else if (recovered) begin
			next_s.primaryMissing = 1'b0;
		end

		// Switchover state machine
		if (!autoActive) begin
			// Manual mode tracks the selection so automatic resumes from it
			next_s.swState = manualSec ? SW_SECONDARY : SW_PRIMARY;      // RULE_05
		end else begin
			unique case (s.swState)
				SW_PRIMARY: begin
					if (s.primaryMissing)
						next_s.swState = SW_ARMED;
				end
				SW_ARMED: begin
					if (secRise)
						next_s.swState = SW_SECONDARY;                   // RULE_02
				end
				SW_SECONDARY: begin
					// Prefer primary reverts; stay on secondary never does
					if (!cfg.stayOnSecondary && recovered) // RULE_04
						next_s.swState = SW_PRIMARY;                     // RULE_06
				end
				default: next_s.swState = SW_PRIMARY;
			endcase
		end
		wantSec = ~cfg.diffSelect & (s.swState == SW_SECONDARY);

		// Hand-over with optional deglitch
		if (wantSec != s.usingSecondary) begin
			next_s.usingSecondary = wantSec;
			next_s.gating = cfg.deglitchEnable;                          // RULE_09
			next_s.pllRefClk = cfg.deglitchEnable ? 1'b0 : selLevel;
		end else if (s.gating) begin
			// Hold low until the new reference is next sampled high
			if (selRise) begin
				next_s.gating = 1'b0;
				next_s.pllRefClk = 1'b1;
			end else begin
				next_s.pllRefClk = 1'b0;                                 // RULE_09
			end
		end else begin
			next_s.pllRefClk = selLevel;
		end
		// Without deglitch a manual switch needs a live target reference  RULE_08

		// Reference divider on the PLL reference
		next_s.refPrev = s.pllRefClk;
		if (rReset) begin
			next_s.rCount = '0;                                          // RULE_15
			next_s.rOut = 1'b0;
		end else if (cfg.rCount <= R_UNITY_MAX) begin
			next_s.rCount = '0;
			next_s.rOut = s.pllRefClk;                                   // RULE_14
		end else if (refRise) begin
			if (s.rCount >= cfg.rCount - R_UNITY_MAX) begin
				next_s.rCount = '0;
				next_s.rOut = 1'b1;
			end else begin
				next_s.rCount = s.rCount + R_UNITY_MAX;
				next_s.rOut = 1'b0;
			end
		end

		// Feedback counter reset, held while any source stays asserted
		next_s.abReset = cfg.resetAllCounters | cfg.resetABCounters | syncHit; // RULE_22
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	// Feedback divider; software keeps prescaler output in range       RULE_21
	prsd_fb_divider #(
		.A_W(A_WIDTH),
		.B_W(B_WIDTH)
	) u_fb (
		.clock       (clock),
		.rst         (rst),
		.vcoLevel    (s.vcoPipe[1]),
		.counterReset(s.abReset),
		.mode        (cfg.prescalerMode),
		.aCount      (cfg.aCount),
		.bCount      (cfg.bCount),
		.fbClk       (fbClk)
	);

	// Outputs straight from state flip-flops
	assign status = '{
		diffReceiverOn:    s.diffRxOn,
		primaryBufferOn:   s.priBufOn,
		secondaryBufferOn: s.secBufOn,
		crystalAmpOn:      s.xtalAmpOn,
		biasShiftDown:     s.biasShift,
		usingSecondary:    s.usingSecondary,
		primaryMissing:    s.primaryMissing,
		pllRefClk:         s.pllRefClk,
		pfdRefClk:         s.rOut,
		pfdFbClk:          fbClk
	};

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence two_falls_quiet;
		(secFall && !priAny && s.missCnt == MISS_N - 2'h1);
	endsequence
	sequence armed_then_rise;
		(autoActive && s.swState == SW_ARMED && secRise);
	endsequence

	a_miss_declare: assert property (two_falls_quiet |=> s.primaryMissing) // RULE_01
		else $error("primary not declared missing");
	a_switch_rise: assert property (armed_then_rise |=> s.swState == SW_SECONDARY ##1 s.usingSecondary) // RULE_02
		else $error("secondary not taken at its rising edge");
	a_revert_four: assert property ((autoActive && !cfg.stayOnSecondary && s.swState == SW_SECONDARY // RULE_03
		&& recovered) |=> s.swState == SW_PRIMARY)
		else $error("no return to primary after clean edges");
	a_inhibit_stay: assert property ((autoActive && cfg.stayOnSecondary && s.swState == SW_SECONDARY) // RULE_04
		|=> s.swState == SW_SECONDARY)
		else $error("left secondary with revert inhibit set");
	a_manual_select: assert property ((!autoActive && !cfg.diffSelect && manualSec) // RULE_07
		|=> s.swState == SW_SECONDARY)
		else $error("manual secondary select ignored");
	a_deglitch_hold: assert property (s.gating |-> !s.pllRefClk) // RULE_09
		else $error("reference edge passed during deglitch hold");
	a_refs_off_reset: assert property ($past(rst) |-> !s.diffRxOn && !s.priBufOn && !s.secBufOn) // RULE_10
		else $error("reference input on after reset");
	a_power_gate: assert property ((!cfg.pllOn || cfg.diffSelect) |=> !s.priBufOn && !s.secBufOn) // RULE_11
		else $error("single-ended buffer powered when it must be off");
	a_bias_shift: assert property ((cfg.dcOffsetEnable && !cfg.diffSelect) |=> s.biasShift) // RULE_12
		else $error("bias shift not applied");
	a_xtal_amp: assert property (s.xtalAmpOn |-> s.diffRxOn) // RULE_13
		else $error("crystal amplifier on outside differential mode");
	a_rdiv_unity: assert property ((!rReset && cfg.rCount <= R_UNITY_MAX) |=> s.rOut == $past(s.pllRefClk)) // RULE_14
		else $error("reference divider not dividing by one");
	a_rdiv_reset: assert property (rReset |=> (s.rCount == '0) && !s.rOut) // RULE_15
		else $error("reference divider not held reset");
	a_sync_gate: assert property ((cfg.syncCtrl == SYNC_OFF && !cfg.resetAllCounters && !cfg.resetABCounters) // RULE_23
		|=> !s.abReset)
		else $error("sync pin reset while disabled");
endmodule
`default_nettype wire

/* verif/prsd_ref_partner.sv */
/*
 * Far side model: primary and secondary references and the VCO.
 * Assumes the bench clock paces every pin; a stopped primary rests low.
 */
`timescale 1ns/1ps
`default_nettype none
module prsd_ref_partner #(
	parameter int PRI_P = 20, // Primary period in clocks
	parameter int SEC_P = 24, // Secondary period in clocks
	parameter int VCO_P = 6   // VCO period, slow enough for the divider
) (
	// Pacing and control
	input  wire logic clock,
	input  wire logic primaryRun,
	// Pins toward the device
	output logic      primaryRefPin,
	output logic      secondaryRefPin,
	output logic      vcoPin
);
	int pc = 0; // Primary phase
	int sc = 0; // Secondary phase
	int vc = 0; // VCO phase
	// Square waves; secondary always toggles, primary only while primaryRun is high
	always @(posedge clock) begin
		pc <= (pc + 1) % PRI_P;
		sc <= (sc + 1) % SEC_P;
		vc <= (vc + 1) % VCO_P;
		primaryRefPin <= primaryRun && (pc < PRI_P / 2);
		secondaryRefPin <= (sc < SEC_P / 2);
		vcoPin <= (vc < VCO_P / 2);
	end
endmodule
`default_nettype wire

/* verif/test_prsd_ref_switch_div.sv */
/*
 * Self-checking bench of the switchover and divider block.
 * Assumes the partner model drives all reference and VCO pins.
 */
`timescale 1ns/1ps
`default_nettype none
module test_prsd_ref_switch_div
	import prsd_pkg::*;
();
	localparam int VP = 6;  // VCO period
	localparam int PP = 20; // Primary period
	localparam int SP = 24; // Secondary period
	typedef struct {
		logic [7:0]  pw;  // pll,diff,xtal,amp,se,ppd,spd,dco
		prsd_pmode_e m;   // Prescaler mode
		logic [5:0]  a;   // Swallow count
		logic [12:0] b;   // Main count
		logic [13:0] r;   // Reference divide
		logic [4:0]  pwr; // diff,pri,sec,xtal,bias expected
		int          n;   // Feedback ratio, -1 skips
		int          rr;  // Reference ratio, -1 skips
	} prsd_row_s;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic primaryRun = 1'b1;
	logic refSelectPin = 1'b0;
	logic syncN = 1'b1;
	logic primaryRefPin, secondaryRefPin, vcoPin;
	prsd_cfg_s cfg = '0;
	prsd_status_s status;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int p;
	prsd_row_s rows [8];
	// Clock
	always #10 clock = ~clock;
	prsd_ref_partner far_u (.clock(clock), .primaryRun(primaryRun), .primaryRefPin(primaryRefPin),
		.secondaryRefPin(secondaryRefPin), .vcoPin(vcoPin));
	prsd_ref_switch_div dut_u (.clock(clock), .rst(rst), .primaryRefPin(primaryRefPin),
		.secondaryRefPin(secondaryRefPin), .vcoPin(vcoPin), .refSelectPin(refSelectPin),
		.syncN(syncN), .cfg(cfg), .status(status));
	task automatic complete_run;
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return status.pfdFbClk;
			1: return status.pfdRefClk;
			3: return status.pllRefClk;
			default: return status.usingSecondary;
		endcase
	endfunction
	// Clocks between the second and third rise, 0 if none
	task automatic period(input int s, output int q);
		int n;
		int t1;
		logic last;
		n = 0;
		t1 = 0;
		q = 0;
		last = 1'b1;
		for (int i = 0; i < 1000 && n < 3; i++) begin
			@(posedge clock);
			#1;
			if (pick(s) === 1'b1 && last === 1'b0) begin
				n++;
				if (n == 2) t1 = i;
				if (n == 3) q = i - t1;
			end
			last = pick(s);
		end
	endtask
	task automatic waitFor(input logic v, input int lim);
		for (int i = 0; i < lim && pick(2) !== v; i++) begin
			@(posedge clock);
			#1;
		end
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		rows = '{'{8'h88, PS_FD2, 5, 3, 3, 5'h0C, 6, 3}, '{8'h8B, PS_DM2, 1, 3, 0, 5'h09, 7, 1},
			'{8'h88, PS_DM4, 1, 3, 1, 5'h0C, 13, 1}, '{8'h88, PS_FD3, 0, 1, 2, 5'h0C, 3, 2},
			'{8'hF0, PS_DM8, 0, 3, 1, 5'h12, 24, 1}, '{8'hD0, PS_DM32, 0, 1, 1, 5'h10, 32, 1},
			'{8'h08, PS_FD1, 0, 3, 1, 5'h00, 3, 0}, '{8'h8C, PS_DM16, 2, 3, 1, 5'h04, 50, 0}};
		repeat (10) @(posedge clock);
		#1 check("status in reset", status, '0);
		@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 check("status after reset", status, '0);
		// Table rows: main count three or more, or bypassed with zero swallow
		foreach (rows[i]) begin
			@(posedge clock);
			{cfg.pllOn, cfg.diffSelect, cfg.crystalMode, cfg.crystalAmpEnable, cfg.singleEndedEnable,
				cfg.primaryPowerDown, cfg.secondaryPowerDown, cfg.dcOffsetEnable} <= rows[i].pw;
			cfg.prescalerMode <= rows[i].m;
			cfg.aCount <= rows[i].a;
			cfg.bCount <= rows[i].b;
			cfg.rCount <= rows[i].r;
			period(0, p);
			if (rows[i].n >= 0) check("feedback period", p, rows[i].n * VP);
			period(1, p);
			if (rows[i].rr >= 0) check("reference period", p, rows[i].rr * PP);
			check("power outputs", {status.diffReceiverOn, status.primaryBufferOn, status.secondaryBufferOn,
				status.crystalAmpOn, status.biasShiftDown}, rows[i].pwr);
		end
		// Automatic switchover, prefer primary
		@(posedge clock);
		cfg <= '{pllOn: 1'b1, singleEndedEnable: 1'b1, autoMode: 1'b1, deglitchEnable: 1'b1,
			prescalerMode: PS_FD1, default: '0};
		repeat (100) @(posedge clock);
		primaryRun <= 1'b0;
		waitFor(1'b1, 200);
		check("missing flag", status.primaryMissing, 1'b1);
		check("on secondary", status.usingSecondary, 1'b1);
		period(1, p);
		check("secondary period", p, SP);
		@(posedge clock);
		primaryRun <= 1'b1;
		repeat (2 * PP) @(posedge clock);
		#1 check("early revert", status.usingSecondary, 1'b1);
		waitFor(1'b0, 300);
		check("reverted", {status.primaryMissing, status.usingSecondary}, 2'h0);
		period(3, p);
		check("pll reference period", p, PP);
		// Stay on secondary until software steps in
		@(posedge clock);
		cfg.stayOnSecondary <= 1'b1;
		primaryRun <= 1'b0;
		waitFor(1'b1, 200);
		@(posedge clock);
		primaryRun <= 1'b1;
		repeat (300) @(posedge clock);
		#1 check("inhibited revert", status.usingSecondary, 1'b1);
		@(posedge clock);
		cfg.autoMode <= 1'b0;
		waitFor(1'b0, 100);
		check("manual primary", status.usingSecondary, 1'b0);
		@(posedge clock);
		cfg.autoMode <= 1'b1;
		repeat (60) @(posedge clock);
		#1 check("auto again", status.usingSecondary, 1'b0);
		// Manual select by pin, then by register; both references toggle
		@(posedge clock);
		cfg.autoMode <= 1'b0;
		cfg.selectPinEnable <= 1'b1;
		refSelectPin <= 1'b1;
		waitFor(1'b1, 100);
		check("pin select", status.usingSecondary, 1'b1);
		@(posedge clock);
		cfg.selectPinEnable <= 1'b0;
		waitFor(1'b0, 100);
		check("pin ignored", status.usingSecondary, 1'b0);
		@(posedge clock);
		cfg.manualSecondary <= 1'b1;
		waitFor(1'b1, 100);
		check("register select", status.usingSecondary, 1'b1);
		// Counter resets held as levels, sync pin only when enabled
		@(posedge clock);
		cfg.manualSecondary <= 1'b0;
		cfg.prescalerMode <= PS_FD2;
		cfg.bCount <= 13'h0003;
		cfg.rCount <= 14'h0003;
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			cfg.resetAllCounters <= (k == 0);
			cfg.resetABCounters <= (k == 1);
			cfg.resetRDivider <= (k == 2);
			syncN <= (k < 3);
			cfg.syncCtrl <= (k == 4) ? 2'h1 : SYNC_OFF;
			period(k == 2, p);
			check("held reset", p, (k == 3) ? 6 * VP : 0);
		end
		@(posedge clock);
		syncN <= 1'b1;
		cfg.syncCtrl <= SYNC_OFF;
		period(0, p);
		check("after sync", p, 6 * VP);
		complete_run();
	end
endmodule
`default_nettype wire
